/* verilog/program_counter_stack_indirect.sv */
`timescale 1ns/1ps
module program_counter_stack_indirect
	import pc_stack_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic op_valid,
	input wire seq_op_e op,
	input wire logic [PAGE_BITS-1:0] target_addr,
	input wire logic [PC_WIDTH-1:0] intr_vector,
	input wire logic [DATA_WIDTH-1:0] low_write_data,
	input wire logic hold_write,
	input wire logic [DATA_WIDTH-1:0] hold_write_data,
	input wire logic pointer_write,
	input wire logic [DATA_WIDTH-1:0] pointer_write_data,
	input wire logic [DATA_WIDTH-1:0] status_in,
	input wire logic indirect_read,
	input wire logic indirect_write,
	input wire logic [DATA_WIDTH-1:0] indirect_wdata,
	input wire logic [DATA_WIDTH-1:0] file_rdata,
	output logic [PC_WIDTH-1:0] program_counter,
	output logic [DATA_WIDTH-1:0] counter_low_byte,
	output logic [DATA_WIDTH-1:0] upper_address_holding,
	output logic [DATA_WIDTH-1:0] file_pointer,
	output logic [EFF_ADDR_WIDTH-1:0] eff_addr,
	output logic file_read,
	output logic file_write,
	output logic [DATA_WIDTH-1:0] file_wdata,
	output logic [DATA_WIDTH-1:0] indirect_rdata,
	output logic indirect_rdata_valid
);
	logic [PC_WIDTH-1:0] pc_reg;
	logic [PC_WIDTH-1:0] pc_next;
	logic [DATA_WIDTH-1:0] hold_reg;
	logic [DATA_WIDTH-1:0] fp_reg;
	logic [PC_WIDTH-1:0] stack_top;
	logic do_push;
	logic do_pop;
	logic [EFF_ADDR_WIDTH-1:0] eff_addr_reg;
	logic file_read_reg;
	logic file_write_reg;
	logic [DATA_WIDTH-1:0] file_wdata_reg;
	logic rd_pending_reg;
	logic rd_self_reg;
	logic [DATA_WIDTH-1:0] ind_rdata_reg;
	logic ind_valid_reg;
	logic self_addr;

	// Page target: holding bit three, then a zero bit, over eleven instruction bits
	function automatic logic [PC_WIDTH-1:0] page_target(
		input logic [DATA_WIDTH-1:0] hold,
		input logic [PAGE_BITS-1:0] addr
	);
		page_target = {hold[PAGE_SEL_BIT], 1'b0, addr};
	endfunction

	// Stack strobes
	assign do_push = op_valid && (op == OP_CALL || op == OP_INTR);
	assign do_pop = op_valid && op == OP_RETURN;

	return_stack #(
		.DEPTH(DEPTH),
		.WIDTH(PC_WIDTH)
	) u_stack (
		.mclk(mclk),
		.reset_n(reset_n),
		.push(do_push),
		.pop(do_pop),
		.push_data(pc_reg),
		.top_data(stack_top)
	);

	// Next counter value
	always_comb begin
		pc_next = pc_reg;
		if (op_valid) begin
			case (op)
				OP_NEXT: begin
					pc_next = pc_reg + PC_ONE;
				end
				OP_HOLD: begin
					pc_next = pc_reg;
				end
				OP_JUMP, OP_CALL: begin
					pc_next = page_target(hold_reg, target_addr);
				end
				OP_INTR: begin
					pc_next = intr_vector;
				end
				OP_RETURN: begin
					pc_next = stack_top;
				end
				OP_LOW_WRITE: begin
					// High part comes only from holding register
					pc_next = {hold_reg[HIGH_WIDTH-1:0], low_write_data};
				end
				default: begin
					pc_next = pc_reg;
				end
			endcase
		end
	end

	// Program counter
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			pc_reg <= PC_RESET;
		end else begin
			pc_reg <= pc_next;
		end
	end

	// Holding register, written only by software
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			hold_reg <= HOLD_RESET;
		end else if (hold_write) begin
			hold_reg <= hold_write_data;
		end
	end

	// File pointer
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			fp_reg <= FILE_PTR_RESET;
		end else if (pointer_write) begin
			fp_reg <= pointer_write_data;
		end
	end

	assign self_addr = fp_reg == INDIRECT_SELF;

	// Indirect access toward register file
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			eff_addr_reg <= '0;
			file_read_reg <= 1'b0;
			file_write_reg <= 1'b0;
			file_wdata_reg <= '0;
		end else begin
			// Bank bit is read but forced low here
			eff_addr_reg <= {status_in[BANK_SEL_BIT] & 1'b0, fp_reg};
			file_read_reg <= indirect_read && !self_addr;
			file_write_reg <= indirect_write && !self_addr;
			file_wdata_reg <= indirect_wdata;
		end
	end

	// Read returns one cycle after file strobe
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			rd_pending_reg <= 1'b0;
			rd_self_reg <= 1'b0;
			ind_rdata_reg <= '0;
			ind_valid_reg <= 1'b0;
		end else begin
			rd_pending_reg <= indirect_read;
			rd_self_reg <= self_addr;
			ind_valid_reg <= rd_pending_reg;
			if (rd_pending_reg) begin
				ind_rdata_reg <= rd_self_reg ? SELF_READ_VALUE
					: file_rdata;
			end
		end
	end

	// Outputs straight from flip-flops
	assign program_counter = pc_reg;
	assign counter_low_byte = pc_reg[DATA_WIDTH-1:0];
	assign upper_address_holding = hold_reg;
	assign file_pointer = fp_reg;
	assign eff_addr = eff_addr_reg;
	assign file_read = file_read_reg;
	assign file_write = file_write_reg;
	assign file_wdata = file_wdata_reg;
	assign indirect_rdata = ind_rdata_reg;
	assign indirect_rdata_valid = ind_valid_reg;

	// Counter advances by one on a plain step
	a_pc_increment: assert property (
		@(posedge mclk) disable iff (!reset_n)
		op_valid && op == OP_NEXT |=> pc_reg == $past(pc_reg) + PC_ONE)
		else $error("counter did not advance by one");

	// Counter holds with no op or a hold op
	a_pc_idle: assert property (
		@(posedge mclk) disable iff (!reset_n)
		(!op_valid || op == OP_HOLD) |=> pc_reg == $past(pc_reg))
		else $error("counter moved without an op");

	// Page bit on jumps and calls, old holding value used
	a_jump_page: assert property (
		@(posedge mclk) disable iff (!reset_n)
		op_valid && (op == OP_JUMP || op == OP_CALL) |=>
		pc_reg == {$past(hold_reg[PAGE_SEL_BIT]), 1'b0, $past(target_addr)})
		else $error("jump target page wrong");

	// Eleven target bits on jumps and calls
	a_jump_low: assert property (
		@(posedge mclk) disable iff (!reset_n)
		op_valid && (op == OP_JUMP || op == OP_CALL) |=>
		pc_reg[PAGE_BITS-1:0] == $past(target_addr))
		else $error("jump target offset wrong");

	// Low byte write takes high part from holding
	a_low_write: assert property (
		@(posedge mclk) disable iff (!reset_n)
		op_valid && op == OP_LOW_WRITE |=>
		pc_reg == {$past(hold_reg[HIGH_WIDTH-1:0]), $past(low_write_data)})
		else $error("low byte write did not load high part");

	// Interrupt branch loads its vector
	a_intr_vector: assert property (
		@(posedge mclk) disable iff (!reset_n)
		op_valid && op == OP_INTR |=> pc_reg == $past(intr_vector))
		else $error("interrupt vector not loaded");

	// Call then return lands on the calling address
	a_call_return: assert property (
		@(posedge mclk) disable iff (!reset_n)
		op_valid && op == OP_CALL && !hold_write ##1
		op_valid && op == OP_RETURN |=> pc_reg == $past(pc_reg, 2))
		else $error("return did not restore full counter");

	// Interrupt then return resumes the interrupted address
	a_intr_return: assert property (
		@(posedge mclk) disable iff (!reset_n)
		op_valid && op == OP_INTR ##1
		op_valid && op == OP_RETURN |=> pc_reg == $past(pc_reg, 2))
		else $error("return from interrupt lost address");

	// Every return kind loads the stack top
	a_pop_restore: assert property (
		@(posedge mclk) disable iff (!reset_n)
		op_valid && op == OP_RETURN |=> pc_reg == $past(stack_top))
		else $error("return did not load stack top");

	// Stack traffic leaves the holding register alone
	a_hold_stable: assert property (
		@(posedge mclk) disable iff (!reset_n)
		(do_push || do_pop) && !hold_write |=> $stable(hold_reg))
		else $error("holding register changed on stack op");

	// Software write reaches the holding register
	a_hold_load: assert property (
		@(posedge mclk) disable iff (!reset_n)
		hold_write |=> hold_reg == $past(hold_write_data))
		else $error("holding register write lost");

	// Software write reaches the file pointer
	a_pointer_load: assert property (
		@(posedge mclk) disable iff (!reset_n)
		pointer_write |=> fp_reg == $past(pointer_write_data))
		else $error("file pointer write lost");

	// Indirect read forwarded with pointer address
	a_ind_read: assert property (
		@(posedge mclk) disable iff (!reset_n)
		indirect_read && !self_addr |=> file_read_reg
		&& eff_addr_reg[DATA_WIDTH-1:0] == $past(fp_reg))
		else $error("indirect read not forwarded");

	// Indirect write forwarded with address and data
	a_ind_write: assert property (
		@(posedge mclk) disable iff (!reset_n)
		indirect_write && !self_addr |=> file_write_reg
		&& eff_addr_reg[DATA_WIDTH-1:0] == $past(fp_reg)
		&& file_wdata_reg == $past(indirect_wdata))
		else $error("indirect write not forwarded");

	// No file strobe without an indirect access
	a_no_read: assert property (
		@(posedge mclk) disable iff (!reset_n)
		!indirect_read |=> !file_read_reg)
		else $error("file read without indirect read");

	a_no_write: assert property (
		@(posedge mclk) disable iff (!reset_n)
		!indirect_write |=> !file_write_reg)
		else $error("file write without indirect write");

	// Read data returns two cycles after the request
	a_read_data: assert property (
		@(posedge mclk) disable iff (!reset_n)
		indirect_read && !self_addr |-> ##2 ind_valid_reg
		&& ind_rdata_reg == $past(file_rdata))
		else $error("indirect read data wrong");

	// Valid only ever follows a request
	a_valid_pulse: assert property (
		@(posedge mclk) disable iff (!reset_n)
		!indirect_read |-> ##2 !ind_valid_reg)
		else $error("read valid without request");

	// Self-addressed read yields zero, no file strobe
	a_self_read: assert property (
		@(posedge mclk) disable iff (!reset_n)
		indirect_read && self_addr |-> ##2 ind_valid_reg
		&& ind_rdata_reg == SELF_READ_VALUE)
		else $error("self indirect read not zero");

	a_self_no_read: assert property (
		@(posedge mclk) disable iff (!reset_n)
		indirect_read && self_addr |=> !file_read_reg)
		else $error("self indirect read reached file");

	// Self-addressed write stores nothing
	a_self_write: assert property (
		@(posedge mclk) disable iff (!reset_n)
		indirect_write && self_addr |=> !file_write_reg)
		else $error("self indirect write reached file");

	// Bank bit never reaches the effective address
	a_bank_ignored: assert property (
		@(posedge mclk) disable iff (!reset_n)
		1'b1 |=> eff_addr_reg == {1'b0, $past(fp_reg)})
		else $error("effective address wrong");

	// Main scenarios reached
	c_call: cover property (@(posedge mclk) do_push);
	c_return: cover property (@(posedge mclk) do_pop);
	c_self_read: cover property (@(posedge mclk) indirect_read && self_addr);
	c_nine_push: cover property (@(posedge mclk) do_push [*8] ##1 do_push);
	c_intr: cover property (@(posedge mclk) op_valid && op == OP_INTR);
endmodule

/* verilog/pc_stack_pkg.sv */
package pc_stack_pkg;
	// Widths and stack depth
	localparam int PC_WIDTH = 13;
	localparam int PAGE_BITS = 11;
	localparam int HIGH_WIDTH = 5;
	localparam int STACK_DEPTH = 8;
	localparam int PTR_WIDTH = 3;
	localparam int DATA_WIDTH = 8;
	localparam int EFF_ADDR_WIDTH = 9;
	// Field positions
	localparam int PAGE_SEL_BIT = 3;
	localparam int BANK_SEL_BIT = 7;
	// Reset values and other constants
	localparam logic [12:0] PC_RESET = 13'h0000;
	localparam logic [7:0] HOLD_RESET = 8'h00;
	localparam logic [7:0] FILE_PTR_RESET = 8'h00;
	localparam logic [7:0] INDIRECT_SELF = 8'h00;
	localparam logic [7:0] SELF_READ_VALUE = 8'h00;
	localparam logic [12:0] PC_ONE = 13'h0001;

	// Sequencing operations from the decoder
	typedef enum logic [2:0] {
		OP_NEXT,
		OP_HOLD,
		OP_JUMP,
		OP_CALL,
		OP_INTR,
		OP_RETURN,
		OP_LOW_WRITE
	} seq_op_e;
endpackage

/* verilog/return_stack.sv */
`timescale 1ns/1ps
module return_stack
	import pc_stack_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH,
	parameter int WIDTH = PC_WIDTH
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic push,
	input wire logic pop,
	input wire logic [WIDTH-1:0] push_data,
	output logic [WIDTH-1:0] top_data
);
	logic [WIDTH-1:0] entry_mem [DEPTH];
	logic [PTR_WIDTH-1:0] ptr_reg;
	logic [PTR_WIDTH-1:0] top_idx;

	// Top entry sits one below the write pointer
	assign top_idx = ptr_reg - {{(PTR_WIDTH-1){1'b0}}, 1'b1};
	assign top_data = entry_mem[top_idx];

	// Pointer wraps, no overflow flag
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			ptr_reg <= '0;
		end else if (push) begin
			ptr_reg <= ptr_reg + {{(PTR_WIDTH-1){1'b0}}, 1'b1};
		end else if (pop) begin
			ptr_reg <= top_idx;
		end
	end

	// Entry storage, ninth push overwrites first
	always_ff @(posedge mclk) begin
		if (push) begin
			entry_mem[ptr_reg] <= push_data;
		end
	end

	a_stack_wrap: assert property (
		@(posedge mclk) disable iff (!reset_n)
		push && !pop |=> ptr_reg == $past(ptr_reg) + 3'h1)
		else $error("stack pointer did not advance with wrap");
	// Top shows the pushed value in the pop cycle itself
	a_push_pop: assert property (
		@(posedge mclk) disable iff (!reset_n)
		push && !pop ##1 pop && !push |-> top_data == $past(push_data))
		else $error("pop did not return last pushed value");
endmodule

/* verification/reg_file_model.sv */
`timescale 1ns/1ps
// Register file behind the indirect port
module reg_file_model
	import pc_stack_pkg::*;
(
	input wire logic mclk,
	input wire logic file_read,
	input wire logic file_write,
	input wire logic [EFF_ADDR_WIDTH-1:0] eff_addr,
	input wire logic [DATA_WIDTH-1:0] file_wdata,
	output logic [DATA_WIDTH-1:0] file_rdata
);
	logic [DATA_WIDTH-1:0] mem [256];
	logic [DATA_WIDTH-1:0] last;
	// Store writes, remember what was last handed back
	always_ff @(posedge mclk) begin
		if (file_write)
			mem[eff_addr[7:0]] <= file_wdata;
		if (file_read)
			last <= file_rdata;
	end
	// Data only while read is up, so stale values never pass
	assign file_rdata = file_read ? mem[eff_addr[7:0]] : ~last;
endmodule

/* verification/program_counter_stack_indirect_tb.sv */
`timescale 1ns/1ps
module program_counter_stack_indirect_tb
	import pc_stack_pkg::*;
;
	logic mclk, reset_n, op_valid, hold_write, pointer_write;
	seq_op_e op;
	logic [10:0] target_addr;
	logic [12:0] intr_vector, program_counter;
	logic [7:0] low_write_data, hold_write_data, pointer_write_data;
	logic [7:0] status_in, indirect_wdata, file_rdata, counter_low_byte;
	logic [7:0] upper_address_holding, file_pointer, file_wdata;
	logic [7:0] indirect_rdata;
	logic indirect_read, indirect_write, file_read, file_write;
	logic indirect_rdata_valid;
	logic [8:0] eff_addr;
	logic [12:0] t [10];
	int err_count = 0;
	int num_checks = 0;
	int cycles = 0;
	program_counter_stack_indirect DUT (.mclk, .reset_n, .op_valid, .op,
		.target_addr, .intr_vector, .low_write_data, .hold_write,
		.hold_write_data, .pointer_write, .pointer_write_data, .status_in,
		.indirect_read, .indirect_write, .indirect_wdata, .file_rdata,
		.program_counter, .counter_low_byte, .upper_address_holding,
		.file_pointer, .eff_addr, .file_read, .file_write, .file_wdata,
		.indirect_rdata, .indirect_rdata_valid);
	reg_file_model far_side (.mclk, .file_read, .file_write, .eff_addr,
		.file_wdata, .file_rdata);
	// Clock
	initial begin
		mclk = 0;
		forever #2.5 mclk = ~mclk;
	end
	// Hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			err_count++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One sequencing op; valid stays up for back to back use
	task automatic op1(input seq_op_e o);
		op = o;
		op_valid = 1;
		@(negedge mclk);
	endtask
	task automatic wr_hold(input logic [7:0] v);
		op_valid = 0;
		hold_write = 1;
		hold_write_data = v;
		@(negedge mclk);
		hold_write = 0;
	endtask
	task automatic wr_ptr(input logic [7:0] v);
		op_valid = 0;
		pointer_write = 1;
		pointer_write_data = v;
		@(negedge mclk);
		pointer_write = 0;
	endtask
	task automatic ind(input logic w, input logic [7:0] d);
		op_valid = 0;
		indirect_write = w;
		indirect_read = !w;
		indirect_wdata = d;
		@(negedge mclk);
		indirect_write = 0;
		indirect_read = 0;
	endtask
	// Counting, holding, low byte write and wrap
	task automatic t_count();
		chk(program_counter, 0);
		chk(upper_address_holding, 0);
		op1(OP_NEXT);
		chk(program_counter, 1);
		op1(OP_HOLD);
		wr_hold(8'h1f);
		chk(program_counter, 1);
		low_write_data = 8'hff;
		op1(OP_LOW_WRITE);
		chk(program_counter, 13'h1fff);
		chk(counter_low_byte, 8'hff);
		op1(OP_NEXT);
		chk(program_counter, 0);
	endtask
	// Page bit from holding register on jumps
	task automatic t_jump();
		target_addr = 11'h7ab;
		wr_hold(8'h08);
		op1(OP_JUMP);
		chk(program_counter, 13'h17ab);
		wr_hold(8'h00);
		op1(OP_JUMP);
		chk(program_counter, 13'h07ab);
	endtask
	// Nine calls wrap the stack, then unwind
	task automatic t_stack();
		wr_hold(8'h08);
		for (int i = 1; i <= 9; i++) begin
			target_addr = 11'(i * 273);
			t[i] = {2'b10, target_addr};
			op1(OP_CALL);
			chk(program_counter, t[i]);
		end
		for (int k = 1; k <= 9; k++) begin
			op1(OP_RETURN);
			chk(program_counter, t[k == 9 ? 8 : 9 - k]);
		end
		chk(upper_address_holding, 8'h08);
		op1(OP_INTR);
		chk(program_counter, 13'h0abc);
		op1(OP_RETURN);
		chk(program_counter, t[8]);
	endtask
	// Indirect port through the pointer, bank bit set
	task automatic t_indirect();
		wr_ptr(8'h20);
		chk(file_pointer, 8'h20);
		ind(1, 8'h5a);
		chk(file_write, 1);
		chk(eff_addr, 9'h020);
		chk(file_wdata, 8'h5a);
		ind(0, 8'h00);
		chk(file_read, 1);
		@(negedge mclk);
		chk(indirect_rdata_valid, 1);
		chk(indirect_rdata, 8'h5a);
		wr_ptr(8'h00);
		ind(0, 8'h00);
		chk(file_read, 0);
		@(negedge mclk);
		chk(indirect_rdata_valid, 1);
		chk(indirect_rdata, 8'h00);
		ind(1, 8'h33);
		chk(file_write, 0);
	endtask
	initial begin
		reset_n = 0;
		op_valid = 0;
		op = OP_HOLD;
		target_addr = 11'h000;
		intr_vector = 13'h0abc;
		low_write_data = 8'h00;
		hold_write = 0;
		hold_write_data = 8'h00;
		pointer_write = 0;
		pointer_write_data = 8'h00;
		status_in = 8'h80;
		indirect_read = 0;
		indirect_write = 0;
		indirect_wdata = 8'h00;
		repeat (5) @(negedge mclk);
		reset_n = 1;
		t_count();
		t_jump();
		t_stack();
		t_indirect();
		tally_and_finish();
	end
endmodule
